// File: async_memory_model.sv
// Far-side asynchronous memory that times the phases it sees.
`timescale 1ns/1ps
module async_memory_model (
  // Link clock and pins.
  input wire logic clk_in,
  input wire logic [3:0] sel_b_in,
  input wire logic strobe_b_in,
  // Phase lengths of the last access and access count.
  output int setup_out,
  output int strobe_out,
  output int hold_out,
  output int count_out
);
  int s = 0;
  int w = 0;
  int h = 0;
  initial count_out = 0;
  always @(posedge clk_in) begin
    if (&sel_b_in) begin
      if (s + w + h > 0) begin
        setup_out <= s;
        strobe_out <= w;
        hold_out <= h;
        count_out <= count_out + 1;
      end
      s = 0;
      w = 0;
      h = 0;
    end else if (!strobe_b_in)
      w++;
    else if (w == 0)
      s++;
    else
      h++;
  end
endmodule : async_memory_model

// File: memory_space_config_bank.sv
// Memory space configuration bank with asynchronous strobe engine.
`timescale 1ns/1ps
`include "memory_space_config_bank_cfg.svh"
// -----------------------------------------------------------------------
// Overview of operation
// R1: Non-asynchronous kinds ignore the timing fields.
// R2: Software sets memory kind once at start.
// R3: Write setup holds address before strobe.
// R4: Write strobe low for programmed cycles.
// R5: Write hold uses three bits, top separate.
// R6: Read setup holds address before strobe.
// R7: Read strobe low for programmed cycles.
// R8: Read hold keeps address after strobe.
// R9: Output enable shares read setup and hold.
// R10: Turnaround gap after read for asynchronous.
// R11: Memory kind codes decode width and type.
// R12: Narrow instance rejects wide kind codes.
// R13: Bit six picks output clock two.
// R14: Bit five picks read-enable strobe style.
// R15: Bit four extends select with output enable.
// R16: Synchronous write and read latencies exported.
// R17: One SDRAM register serves all SDRAM spaces.
// R18: Software leaves SDRAM register alone mid-access.
// R19: SDRAM banks, rows and columns decoded.
// R20: Refresh enable resets set, raises bus request.
// R21: Self-refresh bit drives clock-enable pin.
// R22: Self-refresh zero drives clock enable high.
// R23: Phases run setup, strobe, then hold.
// -----------------------------------------------------------------------
module memory_space_config_bank #(
  parameter bit NARROW_INSTANCE = 1'b0
) (
  // System clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Output clock one, clocks the asynchronous pins.
  input wire logic output_clock_one_in,
  // Register port.
  input wire logic [3:0] reg_index_in,
  input wire logic reg_write_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // Access requests.
  input wire logic acc_req_in,
  input memory_space_config_pkg::access_t acc_in,
  output logic acc_ready_out,
  output logic acc_done_out,
  input wire logic refresh_tick_in,
  output logic bus_request_out,
  // Asynchronous memory pins.
  output logic [3:0] chip_select_b_out,
  output logic async_write_strobe_b_out,
  output logic async_read_strobe_b_out,
  output logic async_output_enable_b_out,
  output logic [`ADDR_W-1:0] ext_address_out,
  output logic [`BE_W-1:0] byte_enable_b_out,
  // Synchronous and SDRAM settings.
  output memory_space_config_pkg::sync_view_t sync_view_out,
  output memory_space_config_pkg::geometry_t geometry_out,
  output logic [3:0] sdram_space_mask_out,
  output logic refresh_on_out,
  output logic self_refresh_out,
  output logic sdram_clock_enable_pin_out
);
  import memory_space_config_pkg::*;

  function automatic logic kind_is_async(input logic [3:0] k);
    kind_is_async = (k == K_ASYNC8) || (k == K_ASYNC16) ||
      (!NARROW_INSTANCE && ((k == K_ASYNC32) || (k == K_ASYNC64)));
  endfunction : kind_is_async

  function automatic logic kind_is_sdram(input logic [3:0] k);
    kind_is_sdram = (k == K_SDRAM8) || (k == K_SDRAM16) ||
      (!NARROW_INSTANCE && ((k == K_SDRAM32) || (k == K_SDRAM64)));
  endfunction : kind_is_sdram

  function automatic async_timing_t to_timing(input logic [31:0] c);
    to_timing.wr_setup = c[`F_WR_SETUP];
    to_timing.wr_strb = c[`F_WR_STRB];
    to_timing.wr_hold = {c[`B_WR_HOLD_TOP], c[`F_WR_HOLD]};
    to_timing.rd_setup = c[`F_RD_SETUP];
    to_timing.turn = c[`F_TURN];
    to_timing.rd_strb = c[`F_RD_STRB];
    to_timing.rd_hold = c[`F_RD_HOLD];
  endfunction : to_timing

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic [31:0] async_cfg [4];
  logic [31:0] sync_cfg [4];
  logic [31:0] sdram_cfg;
  logic [3:0] space_sdram;

  for (genvar s = 0; s < 4; s++) begin : g_space
    wire logic a_hit = reg_write_in &&
      (reg_index_in == 4'(`IDX_ASYNC0 + s));
    wire logic s_hit = reg_write_in &&
      (reg_index_in == 4'(`IDX_SYNC0 + s));
    always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
        async_cfg[s] <= `ASYNC_RESET;
        sync_cfg[s] <= `SYNC_RESET;
      end else begin
        if (a_hit) async_cfg[s] <= reg_wdata_in;
        if (s_hit) sync_cfg[s] <= reg_wdata_in & `SYNC_MASK;
      end
    end
    // R11 kind decoding
    // R17 shared SDRAM settings
    assign space_sdram[s] = kind_is_sdram(async_cfg[s][`F_KIND]);
  end

  wire logic sd_hit = reg_write_in && (reg_index_in == `IDX_SDRAM);
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) sdram_cfg <= `SDRAM_RESET;
    else if (sd_hit) sdram_cfg <= reg_wdata_in & `SDRAM_MASK;
  end

  wire logic [31:0] rd_word =
    (reg_index_in < `IDX_SYNC0) ? async_cfg[reg_index_in[1:0]] :
    (reg_index_in < `IDX_SDRAM) ? sync_cfg[reg_index_in[1:0]] :
    (reg_index_in == `IDX_SDRAM) ? sdram_cfg : 32'h0;

  // ---------------------------------------------------------------------
  // Settings decode
  // ---------------------------------------------------------------------
  wire logic [31:0] sel_sync = sync_cfg[acc_in.space];
  sync_view_t next_view;
  // R13 clock select
  assign next_view.clock_two = sel_sync[`B_SYNC_CLK];
  // R14 strobe style
  assign next_view.read_style = sel_sync[`B_READ_STYLE];
  // R15 select extension
  assign next_view.select_extend = sel_sync[`B_SEL_EXT];
  // R16 data latencies
  assign next_view.write_latency = sel_sync[`F_SYNC_WL];
  assign next_view.read_latency = sel_sync[`F_SYNC_RL];

  wire logic [1:0] row_sel = sdram_cfg[`F_ROWS];
  wire logic [1:0] col_sel = sdram_cfg[`F_COLS];
  geometry_t next_geom;
  // R19 geometry decode
  assign next_geom.four_banks = sdram_cfg[`B_BANKS];
  assign next_geom.row_bits = (row_sel == 2'h3) ? 4'h0 :
    `ROW_BITS_BASE + {2'h0, row_sel};
  assign next_geom.col_bits = (col_sel == 2'h0) ? `COL_BITS_C0 :
    (col_sel == 2'h1) ? `COL_BITS_C1 :
    (col_sel == 2'h2) ? `COL_BITS_C2 : 4'h0;

  // ---------------------------------------------------------------------
  // Request handling in the system domain
  // ---------------------------------------------------------------------
  logic busy;
  logic req_tgl;
  logic done_tgl;
  logic done_pulse;
  access_t hold_acc;
  async_timing_t hold_tim;

  wire logic [31:0] sel_cfg = async_cfg[acc_in.space];
  wire logic sel_async = kind_is_async(sel_cfg[`F_KIND]);
  wire logic take = acc_req_in & ~busy;
  wire logic next_busy = (busy & ~done_pulse) | (take & sel_async);
  // R1 refuse timing for other kinds
  // R12 narrow instance kinds
  wire logic reject = take & ~sel_async;
  // R20 refresh raises bus request
  wire logic next_bus_req = next_busy |
    (refresh_tick_in & sdram_cfg[`B_REFRESH]);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      busy <= 1'b0;
      req_tgl <= 1'b0;
      hold_acc <= '0;
      hold_tim <= '0;
    end else begin
      busy <= next_busy;
      if (take & sel_async) begin
        req_tgl <= ~req_tgl;
        hold_acc <= acc_in;
        hold_tim <= to_timing(sel_cfg);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      acc_ready_out <= 1'b0;
      acc_done_out <= 1'b0;
      bus_request_out <= 1'b0;
      reg_rdata_out <= 32'h0;
      sync_view_out <= '0;
      geometry_out <= '0;
      sdram_space_mask_out <= 4'h0;
      refresh_on_out <= 1'b0;
      self_refresh_out <= 1'b0;
      sdram_clock_enable_pin_out <= 1'b1;
    end else begin
      acc_ready_out <= ~next_busy;
      acc_done_out <= done_pulse | reject;
      bus_request_out <= next_bus_req;
      reg_rdata_out <= rd_word;
      sync_view_out <= next_view;
      geometry_out <= next_geom;
      sdram_space_mask_out <= space_sdram;
      refresh_on_out <= sdram_cfg[`B_REFRESH];
      // R21 self-refresh only with SDRAM
      self_refresh_out <= sdram_cfg[`B_SELF_REFRESH] & (|space_sdram);
      // R22 clock enable pin level
      sdram_clock_enable_pin_out <= ~sdram_cfg[`B_SELF_REFRESH];
    end
  end

  toggle_pulse_sync u_done_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .toggle_in(done_tgl),
    .pulse_out(done_pulse)
  );

  // ---------------------------------------------------------------------
  // Strobe engine on output clock one
  // ---------------------------------------------------------------------
  logic lrst_meta;
  logic lrst_b;
  logic link_start;
  always_ff @(posedge output_clock_one_in) begin
    lrst_meta <= rst_b_in;
    lrst_b <= lrst_meta;
  end

  toggle_pulse_sync u_req_sync (
    .clk_in(output_clock_one_in),
    .rst_b_in(lrst_b),
    .toggle_in(req_tgl),
    .pulse_out(link_start)
  );

  phase_t phase;
  phase_t next_phase;
  phase_t sd_phase;
  phase_t hd_phase;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic last_read;
  logic [1:0] last_space;

  // The captured request is stable while busy, so it is read directly.
  wire logic wr = hold_acc.write;
  wire logic [3:0] setup_n = wr ? hold_tim.wr_setup : hold_tim.rd_setup;
  wire logic [5:0] strb_n = wr ? hold_tim.wr_strb : hold_tim.rd_strb;
  wire logic [2:0] hold_n = wr ? hold_tim.wr_hold : hold_tim.rd_hold;
  wire logic [5:0] strb_m1 = (strb_n == 6'h0) ? 6'h0 : strb_n - 6'h1;
  // R10 turnaround needed
  wire logic need_turn = last_read & (hold_tim.turn != 2'h0) &
    (wr | (hold_acc.space != last_space));
  assign sd_phase = (setup_n != 4'h0) ? PH_SETUP : PH_STROBE;
  wire logic [5:0] sd_cnt = (setup_n != 4'h0) ?
    {2'h0, setup_n - 4'h1} : strb_m1;
  assign hd_phase = (hold_n != 3'h0) ? PH_HOLD : PH_IDLE;
  wire logic [5:0] hd_cnt = {3'h0, hold_n - 3'h1};

  // R23 phase sequence
  always_comb begin
    next_phase = phase;
    next_cnt = (cnt == 6'h0) ? cnt : cnt - 6'h1;
    unique case (phase)
      PH_IDLE: begin
        if (link_start && need_turn) begin
          next_phase = PH_TURN;
          next_cnt = {4'h0, hold_tim.turn - 2'h1};
        end else if (link_start) begin
          next_phase = sd_phase;
          next_cnt = sd_cnt;
        end
      end
      PH_TURN: begin
        if (cnt == 6'h0) begin
          next_phase = sd_phase;
          next_cnt = sd_cnt;
        end
      end
      PH_SETUP: begin
        if (cnt == 6'h0) begin
          next_phase = PH_STROBE;
          next_cnt = strb_m1;
        end
      end
      PH_STROBE: begin
        if (cnt == 6'h0) begin
          next_phase = hd_phase;
          next_cnt = hd_cnt;
        end
      end
      PH_HOLD: begin
        if (cnt == 6'h0) next_phase = PH_IDLE;
      end
      default: next_phase = PH_IDLE;
    endcase
  end

  wire logic act_next = (next_phase == PH_SETUP) ||
    (next_phase == PH_STROBE) || (next_phase == PH_HOLD);
  wire logic finish = (next_phase == PH_IDLE) &&
    ((phase == PH_STROBE) || (phase == PH_HOLD));

  always_ff @(posedge output_clock_one_in) begin
    if (!lrst_b) begin
      phase <= PH_IDLE;
      cnt <= 6'h0;
      done_tgl <= 1'b0;
      last_read <= 1'b0;
      last_space <= 2'h0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      if (finish) begin
        done_tgl <= ~done_tgl;
        last_read <= ~wr;
        last_space <= hold_acc.space;
      end
    end
  end

  always_ff @(posedge output_clock_one_in) begin
    if (!lrst_b) begin
      chip_select_b_out <= 4'hf;
      async_write_strobe_b_out <= 1'b1;
      async_read_strobe_b_out <= 1'b1;
      async_output_enable_b_out <= 1'b1;
      ext_address_out <= '0;
      byte_enable_b_out <= '1;
    end else begin
      // R3 setup, strobe and hold select
      chip_select_b_out <= act_next ? ~(4'h1 << hold_acc.space) : 4'hf;
      // R4 write strobe
      async_write_strobe_b_out <= ~((next_phase == PH_STROBE) & wr);
      // R7 read strobe
      async_read_strobe_b_out <= ~((next_phase == PH_STROBE) & ~wr);
      // R9 output enable window
      async_output_enable_b_out <= ~(act_next & ~wr);
      ext_address_out <= hold_acc.addr;
      // R5 and R8 byte enables through hold
      byte_enable_b_out <= act_next ? ~hold_acc.be : '1;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  logic [6:0] pre_len;
  logic [6:0] strb_len;
  logic [6:0] post_len;
  logic [2:0] gap_len;
  logic seen_strb;
  wire logic pins_act = ~&chip_select_b_out;
  wire logic strobing = ~async_write_strobe_b_out |
    ~async_read_strobe_b_out;
  always_ff @(posedge output_clock_one_in) begin
    if (!lrst_b) begin
      pre_len <= 7'h0;
      strb_len <= 7'h0;
      post_len <= 7'h0;
      seen_strb <= 1'b0;
      gap_len <= 3'h7;
    end else if (!pins_act) begin
      pre_len <= 7'h0;
      strb_len <= 7'h0;
      post_len <= 7'h0;
      seen_strb <= 1'b0;
      gap_len <= (gap_len == 3'h7) ? gap_len : gap_len + 3'h1;
    end else begin
      gap_len <= 3'h0;
      if (strobing) begin
        seen_strb <= 1'b1;
        strb_len <= strb_len + 7'h1;
      end else if (seen_strb) post_len <= post_len + 7'h1;
      else pre_len <= pre_len + 7'h1;
    end
  end

  property p_wr_setup;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $fell(async_write_strobe_b_out) |->
      pre_len == {3'h0, hold_tim.wr_setup};
  endproperty
  a_wr_setup: assert property (p_wr_setup) // R3
    else $error("write setup length wrong");

  property p_wr_strobe;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $rose(async_write_strobe_b_out) |-> strb_len ==
      ((hold_tim.wr_strb == 6'h0) ? 7'h1 : {1'b0, hold_tim.wr_strb});
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) // R4
    else $error("write strobe width wrong");

  property p_wr_hold;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $rose(&chip_select_b_out) && wr |->
      post_len == {4'h0, hold_tim.wr_hold};
  endproperty
  a_wr_hold: assert property (p_wr_hold) // R5
    else $error("write hold length wrong");

  property p_rd_setup;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $fell(async_read_strobe_b_out) |->
      pre_len == {3'h0, hold_tim.rd_setup};
  endproperty
  a_rd_setup: assert property (p_rd_setup) // R6
    else $error("read setup length wrong");

  property p_rd_strobe;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $rose(async_read_strobe_b_out) |-> strb_len ==
      ((hold_tim.rd_strb == 6'h0) ? 7'h1 : {1'b0, hold_tim.rd_strb});
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) // R7
    else $error("read strobe width wrong");

  property p_rd_hold;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $rose(&chip_select_b_out) && !wr |->
      post_len == {4'h0, hold_tim.rd_hold};
  endproperty
  a_rd_hold: assert property (p_rd_hold) // R8
    else $error("read hold length wrong");

  property p_oe_window;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    pins_act && !wr |-> !async_output_enable_b_out;
  endproperty
  a_oe_window: assert property (p_oe_window) // R9
    else $error("output enable missing in read window");

  property p_turn_gap;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    $fell(&chip_select_b_out) && last_read &&
      (wr || hold_acc.space != last_space) |->
      gap_len >= {1'b0, hold_tim.turn};
  endproperty
  a_turn_gap: assert property (p_turn_gap) // R10
    else $error("turnaround gap too short");

  property p_phase_order;
    @(posedge output_clock_one_in) disable iff (!lrst_b)
    pins_act && seen_strb && !strobing |=> !strobing;
  endproperty
  a_phase_order: assert property (p_phase_order) // R23
    else $error("strobe after hold phase");

  property p_reject;
    @(posedge clk_in) disable iff (!rst_b_in)
    reject |=> acc_done_out && acc_ready_out && !busy;
  endproperty
  a_reject: assert property (p_reject) // R1
    else $error("non-asynchronous access not answered at once");

  property p_cke_pin;
    @(posedge clk_in) disable iff (!rst_b_in)
    sd_hit |=> ##1
      sdram_clock_enable_pin_out == !$past(reg_wdata_in[0], 2);
  endproperty
  a_cke_pin: assert property (p_cke_pin) // R22
    else $error("clock enable pin level wrong");

  property p_refresh_req;
    @(posedge clk_in) disable iff (!rst_b_in)
    refresh_tick_in && sdram_cfg[`B_REFRESH] |=> bus_request_out;
  endproperty
  a_refresh_req: assert property (p_refresh_req) // R20
    else $error("refresh tick did not raise bus request");

  c_write: cover property (@(posedge output_clock_one_in)
    $rose(async_write_strobe_b_out));
  c_read: cover property (@(posedge output_clock_one_in)
    $rose(async_read_strobe_b_out));
  c_turn: cover property (@(posedge output_clock_one_in)
    phase == PH_TURN);
  c_reject: cover property (@(posedge clk_in) reject);
endmodule : memory_space_config_bank

// File: memory_space_config_bank_cfg.svh
// Offsets, field positions and reset values of the memory space bank.
`ifndef MEMORY_SPACE_CONFIG_BANK_CFG_SVH
`define MEMORY_SPACE_CONFIG_BANK_CFG_SVH
// -----------------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------------
`define IDX_ASYNC0 4'h0
`define IDX_SYNC0 4'h4
`define IDX_SDRAM 4'h8
// -----------------------------------------------------------------------
// Reset values and writable masks
// -----------------------------------------------------------------------
`define ASYNC_RESET 32'hffffff03
`define SYNC_RESET 32'h00000000
`define SYNC_MASK 32'h0000007f
`define SDRAM_RESET 32'h0248f000
`define SDRAM_MASK 32'h7efff001
// -----------------------------------------------------------------------
// Asynchronous space fields
// -----------------------------------------------------------------------
`define F_WR_SETUP 31:28
`define F_WR_STRB 27:22
`define F_WR_HOLD 21:20
`define F_RD_SETUP 19:16
`define F_TURN 15:14
`define F_RD_STRB 13:8
`define F_KIND 7:4
`define B_WR_HOLD_TOP 3
`define F_RD_HOLD 2:0
// -----------------------------------------------------------------------
// Synchronous space and SDRAM fields
// -----------------------------------------------------------------------
`define B_SYNC_CLK 6
`define B_READ_STYLE 5
`define B_SEL_EXT 4
`define F_SYNC_WL 3:2
`define F_SYNC_RL 1:0
`define B_BANKS 30
`define F_ROWS 29:28
`define F_COLS 27:26
`define B_REFRESH 25
`define B_SELF_REFRESH 0
`define ROW_BITS_BASE 4'hb
`define COL_BITS_C0 4'h9
`define COL_BITS_C1 4'h8
`define COL_BITS_C2 4'ha
`define ADDR_W 20
`define BE_W 8
`endif

// File: memory_space_config_pkg.sv
// Types shared by the memory space configuration bank.
`include "memory_space_config_bank_cfg.svh"
package memory_space_config_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_TURN = 3'b001,
    PH_SETUP = 3'b010,
    PH_STROBE = 3'b011,
    PH_HOLD = 3'b100
  } phase_t;
  typedef enum logic [3:0] {
    K_ASYNC8 = 4'h0, K_ASYNC16 = 4'h1, K_ASYNC32 = 4'h2,
    K_SDRAM32 = 4'h3, K_SYNC32 = 4'h4, K_SDRAM8 = 4'h8,
    K_SDRAM16 = 4'h9, K_SYNC8 = 4'ha, K_SYNC16 = 4'hb,
    K_ASYNC64 = 4'hc, K_SDRAM64 = 4'hd, K_SYNC64 = 4'he
  } kind_t;
  typedef struct packed {
    logic write;
    logic [1:0] space;
    logic [`ADDR_W-1:0] addr;
    logic [`BE_W-1:0] be;
  } access_t;
  typedef struct packed {
    logic [3:0] wr_setup;
    logic [5:0] wr_strb;
    logic [2:0] wr_hold;
    logic [3:0] rd_setup;
    logic [1:0] turn;
    logic [5:0] rd_strb;
    logic [2:0] rd_hold;
  } async_timing_t;
  typedef struct packed {
    logic clock_two;
    logic read_style;
    logic select_extend;
    logic [1:0] write_latency;
    logic [1:0] read_latency;
  } sync_view_t;
  typedef struct packed {
    logic four_banks;
    logic [3:0] row_bits;
    logic [3:0] col_bits;
  } geometry_t;
endpackage : memory_space_config_pkg

// File: testbench.sv
// Self-checking bench for the memory space configuration bank.
`timescale 1ns/1ps
`include "memory_space_config_bank_cfg.svh"
module testbench;
  import memory_space_config_pkg::*;
  logic clk = 0, lclk = 0, rst_b = 0, wr = 0, req = 0, tick = 0, sd, ak;
  logic [3:0] idx = 0, csb, smask;
  logic [31:0] wd = 0, rd, seed = 32'hc1736361, t;
  logic [31:0] m [16];
  logic [3:0] rl [4] = '{4'hb, 4'hc, 4'hd, 4'h0};
  logic [3:0] cl [4] = '{4'h9, 4'h8, 4'ha, 4'h0};
  logic ready, done, breq, ron, sref, cke, awe_b, are_b, aoe_b;
  logic [`ADDR_W-1:0] ea;
  logic [`BE_W-1:0] be_b;
  access_t acc = '0;
  sync_view_t sv;
  geometry_t geo;
  int n_errors = 0, check_count = 0, ms, mw, mh, mc;
  initial forever #2 clk = ~clk;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  memory_space_config_bank memory_space_config_bank_i (
    .clk_in(clk), .rst_b_in(rst_b), .output_clock_one_in(lclk),
    .reg_index_in(idx), .reg_write_in(wr), .reg_wdata_in(wd),
    .reg_rdata_out(rd), .acc_req_in(req), .acc_in(acc),
    .acc_ready_out(ready), .acc_done_out(done), .refresh_tick_in(tick),
    .bus_request_out(breq), .chip_select_b_out(csb),
    .async_write_strobe_b_out(awe_b), .async_read_strobe_b_out(are_b),
    .async_output_enable_b_out(aoe_b), .ext_address_out(ea),
    .byte_enable_b_out(be_b), .sync_view_out(sv), .geometry_out(geo),
    .sdram_space_mask_out(smask), .refresh_on_out(ron),
    .self_refresh_out(sref), .sdram_clock_enable_pin_out(cke));
  async_memory_model async_memory_model_i (
    .clk_in(lclk), .sel_b_in(csb), .strobe_b_in(awe_b & are_b),
    .setup_out(ms), .strobe_out(mw), .hold_out(mh), .count_out(mc));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task reset_all();
    rst_b = 0;
    step(40);
    rst_b = 1;
    for (int i = 0; i < 16; i++)
      m[i] = i < 4 ? `ASYNC_RESET : i == 8 ? `SDRAM_RESET : 0;
    step(30);
  endtask : reset_all
  task wreg(int i, logic [31:0] d);
    idx = i[3:0];
    wd = d;
    wr = 1;
    step(1);
    wr = 0;
    m[i] = i < 4 ? d : i < 8 ? d & `SYNC_MASK : i == 8 ? d & `SDRAM_MASK : 0;
  endtask : wreg
  task rreg(int i);
    idx = i[3:0];
    step(2);
    chk("rdata", m[i], rd);
  endtask : rreg
  task xfer(logic w, int sp);
    int n, c, s;
    logic [31:0] r;
    n = 0;
    c = mc;
    r = rnd();
    acc.write = w;
    acc.space = sp[1:0];
    acc.addr = r[19:0];
    acc.be = r[27:20];
    req = 1;
    while (ready !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    step(1);
    req = 0;
    while (done !== 1'b1 && n < 9000) begin
      step(1);
      n++;
    end
    chk("done seen", 1, n < 9000);
    step(20);
    chk("access count", c + ak, mc);
    chk("byte enables", {`BE_W{1'b1}}, be_b);
    chk("output enable idle", 1, aoe_b);
    if (ak) begin
      chk("address", acc.addr, ea);
      s = w ? t[27:22] : t[13:8];
      chk("setup", w ? t[31:28] : t[19:16], ms);
      chk("strobe", s == 0 ? 1 : s, mw);
      chk("hold", w ? {t[3], t[21:20]} : t[2:0], mh);
    end
  endtask : xfer
  initial begin
    for (int k = 0; k < 16; k++) begin
      reset_all();
      for (int i = 0; i < 16; i++)
        rreg(i);
      t = rnd();
      t[7:4] = k[3:0];
      wreg(k % 4, t);
      wreg(4 + k % 4, rnd());
      wreg(8, rnd());
      for (int i = 0; i < 16; i++)
        rreg(i);
      acc.space = k[1:0];
      step(2);
      sd = k == 3 || k == 8 || k == 9 || k == 13;
      ak = k == 0 || k == 1 || k == 2 || k == 12;
      chk("sync view", m[4 + k % 4][6:0], sv);
      chk("geometry", {m[8][30], rl[m[8][29:28]], cl[m[8][27:26]]}, geo);
      chk("sdram mask", 32'(sd) << k % 4, smask);
      chk("refresh on", m[8][25], ron);
      chk("self refresh", m[8][0] & sd, sref);
      chk("cke pin", !m[8][0], cke);
      tick = 1;
      step(1);
      chk("bus request", m[8][25], breq);
      tick = 0;
      step(2);
      xfer(0, k % 4);
      xfer(1, k % 4);
    end
    report_and_stop();
  end
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end
endmodule : testbench

// File: toggle_pulse_sync.sv
// Toggle crossing that turns a far-domain toggle into a local pulse.
`timescale 1ns/1ps
module toggle_pulse_sync (
  // Local clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Toggle from the far domain and local pulse.
  input wire logic toggle_in,
  output logic pulse_out
);
  logic meta;
  logic sync;
  logic last;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= toggle_in;
      sync <= meta;
      last <= sync;
    end
  end
  assign pulse_out = sync ^ last;
endmodule : toggle_pulse_sync
